// file: inc/fep_pkg.sv
// package for the flash erase/protection host controller
package fep_pkg;
  // register offsets (byte addresses, one word each)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  // control field positions
  localparam int CTRL_GO_BIT   = 0;
  localparam int CTRL_OP_LSB   = 1;
  localparam int CTRL_OP_W     = 3;
  localparam int CTRL_TMP_BIT  = 4;
  // status field positions
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_WIN_BIT    = 1;
  localparam int ST_REJ_BIT    = 2;
  localparam int ST_PROT_BIT   = 3;
  // timing: 40 MHz clock
  localparam int CLK_HZ        = 40_000_000;
  localparam int CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam int WR_PULSE_NS   = 35;
  localparam int WR_PULSE_CYC  = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_ACC_NS     = 70;
  localparam int RD_ACC_CYC    = (RD_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROT_PULSE_NS = 10_000;
  localparam int PROT_CYC      = (PROT_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int GLITCH_NS     = 5;
  localparam int GLITCH_CYC    = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic [7:0] UNPROT_CODE = 8'h00;
  localparam int DQ_WIN_BIT    = 3;
  // operation codes
  typedef enum logic [2:0] {
    OP_WRITE  = 3'h0,
    OP_READ   = 3'h1,
    OP_ADDSEC = 3'h2,
    OP_PROT   = 3'h3,
    OP_UNPROT = 3'h4,
    OP_VERIFY = 3'h5
  } fep_op_t;
  // pin bundle driven toward the flash
  typedef struct packed {
    logic       ce_n;
    logic       we_n;
    logic       oe_n;
    logic       oe_hv;
    logic       addr_bit_nine_hv;
    logic       rst_hv;
    logic [17:0] addr;
  } fep_pins_t;
endpackage

// file: rtl/fep_host.sv
// host controller driving the flash erase/protection pins over wishbone
// Notes on behaviour
// - software reads flag before and after each added sector erase command; host samples it each read, sets rejected on a low then high pair.
// - write needs select and write strobe low with output strobe high.
// - protect: high voltage on addr nine and output strobe, pulse write.
// - unlock: high voltage on output strobe, addr nine, addr six high.
// - software protects every sector before whole-array unlock; host does not check it.
module fep_host
  import fep_pkg::*;
#(
  parameter int PROT_CYCLES = PROT_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // classic wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // flash control and address pins
  output fep_pins_t        pins,
  // flash data lines, three signals
  input  wire logic [7:0]  data_lines_i,
  output logic      [7:0]  data_lines_o,
  output logic             data_lines_oe
);
  // the pulse counter is 16 bits wide, so longer pulses cannot be timed
  if (PROT_CYCLES < 1 || PROT_CYCLES > 65536) begin : g_prot_check
    $error("PROT_CYCLES must lie between 1 and 65536");
  end

  typedef enum logic [4:0] {
    S_IDLE  = 5'b00001,
    S_SETUP = 5'b00010,
    S_PULSE = 5'b00100,
    S_READ  = 5'b01000,
    S_DONE  = 5'b10000
  } fep_state_t;

  fep_state_t  state;
  fep_op_t     op;
  logic        tmp_unprot;
  logic [17:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic [15:0] cnt;
  logic        pre_win;
  logic        rejected;
  logic        prot_seen;
  logic        wb_hit;

  function automatic logic [15:0] cyc16(input int n);
    return 16'(n - 1);
  endfunction

  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // ack one cycle after request, dropped in the cycle after
  always_ff @(posedge clk) begin
    if (rst) wb_ack_o <= 1'b0;
    else     wb_ack_o <= wb_hit;
  end

  // register writes; go ignored while busy
  always_ff @(posedge clk) begin
    if (rst) begin
      op         <= OP_READ;
      tmp_unprot <= 1'b0;
      addr       <= 18'h00000;
      wdata      <= RST_DATA;
    end else if (wb_hit && wb_we_i && state == S_IDLE) begin
      if (wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
        op         <= fep_op_t'(wb_dat_i[CTRL_OP_LSB +: CTRL_OP_W]);
        tmp_unprot <= wb_dat_i[CTRL_TMP_BIT];
      end
      if (wb_adr_i == REG_ADDR)  addr  <= wb_dat_i[17:0];
      if (wb_adr_i == REG_WDATA && wb_sel_i[0]) wdata <= wb_dat_i[7:0];
    end
  end

  // read mux; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (rst) wb_dat_o <= 32'h00000000;
    else if (wb_hit && !wb_we_i) begin
      case (wb_adr_i)
        REG_CTRL:   wb_dat_o <= {27'h0, tmp_unprot, op, 1'b0};
        REG_ADDR:   wb_dat_o <= {14'h0, addr};
        REG_WDATA:  wb_dat_o <= {24'h0, wdata};
        REG_STATUS: wb_dat_o <= {28'h0, prot_seen, rejected,
                                 rdata[DQ_WIN_BIT], state != S_IDLE};
        REG_RDATA:  wb_dat_o <= {24'h0, rdata};
        default:    wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  logic go;
  assign go = wb_hit && wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]
              && wb_dat_i[CTRL_GO_BIT] && state == S_IDLE;

  // pin sequencer: setup, strobe pulse, read sample
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= S_IDLE;
      cnt   <= 16'h0000;
    end else begin
      case (state)
        S_IDLE: if (go) state <= S_SETUP;
        S_SETUP: begin
          state <= (op == OP_READ || op == OP_VERIFY) ? S_READ : S_PULSE;
          cnt   <= (op == OP_PROT || op == OP_UNPROT) ?
                   cyc16(PROT_CYCLES) : cyc16(WR_PULSE_CYC);
        end
        S_PULSE: begin
          // pulse held well over glitch width so it counts as a write
          if (cnt == 16'h0000) state <= S_DONE;
          else cnt <= cnt - 16'h0001;
          if (cnt == cyc16(WR_PULSE_CYC)) cnt <= cnt - 16'h0001;
        end
        S_READ: begin
          if (cnt == 16'h0000) state <= S_DONE;
          else cnt <= cnt - 16'h0001;
        end
        S_DONE: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
      if (state == S_SETUP && (op == OP_READ || op == OP_VERIFY))
        cnt <= cyc16(RD_ACC_CYC);
    end
  end

  // capture read data at end of access
  always_ff @(posedge clk) begin
    if (rst) rdata <= RST_DATA;
    else if (state == S_READ && cnt == 16'h0000) rdata <= data_lines_i;
  end

  // window flag before an added sector command; high after means rejected
  always_ff @(posedge clk) begin
    if (rst) begin
      pre_win   <= 1'b0;
      rejected  <= 1'b0;
      prot_seen <= 1'b0;
    end else if (state == S_READ && cnt == 16'h0000) begin
      pre_win  <= data_lines_i[DQ_WIN_BIT];
      rejected <= op == OP_READ && pre_win == 1'b0
                  && data_lines_i[DQ_WIN_BIT];
      if (op == OP_VERIFY)
        prot_seen <= data_lines_i[0];
    end
  end

  // pin drive: write strobe only with select low and output strobe high
  always_comb begin
    pins.addr   = addr;
    pins.ce_n   = !(state == S_PULSE || state == S_READ);
    pins.we_n   = !(state == S_PULSE);
    pins.oe_n   = !(state == S_READ);
    pins.oe_hv  = (op == OP_PROT || op == OP_UNPROT) &&
                  (state == S_SETUP || state == S_PULSE);
    pins.addr_bit_nine_hv = (op == OP_PROT || op == OP_UNPROT ||
                             op == OP_VERIFY) &&
                            state != S_IDLE && state != S_DONE;
    pins.rst_hv = tmp_unprot;
    // software must protect every sector first; unlock does not check it
    if (op == OP_UNPROT) pins.addr[6] = 1'b1;
    if (op == OP_PROT)   pins.addr[6] = 1'b0;
    // bit one stays as software set it, so identity codes stay reachable
    if (op == OP_VERIFY) pins.addr[0] = 1'b0;
    if (op == OP_VERIFY) pins.addr[6] = 1'b0;
    // protect/unlock raise the output strobe to high voltage instead
    if (op == OP_PROT || op == OP_UNPROT)
      pins.oe_n = 1'b1;
  end

  // data lines driven during write pulses of normal commands and for one cycle after
  always_ff @(posedge clk) begin
    if (rst) begin
      data_lines_o  <= RST_DATA;
      data_lines_oe <= 1'b0;
    end else begin
      data_lines_o  <= wdata;
      data_lines_oe <= (state == S_SETUP || state == S_PULSE) &&
                       (op == OP_WRITE || op == OP_ADDSEC);
    end
  end

  // write strobe low only while select low and output strobe high
  a_we_qual: assert property (@(posedge clk) disable iff (rst)
    !pins.we_n |-> !pins.ce_n && pins.oe_n)
    else $error("write strobe without valid qualifiers");
  a_no_rd_wr: assert property (@(posedge clk) disable iff (rst)
    !pins.oe_n |-> pins.we_n)
    else $error("output strobe low during write");
  a_pulse_width: assert property (@(posedge clk) disable iff (rst)
    $fell(pins.we_n) |-> !pins.we_n [*2])
    else $error("write pulse too short");
  a_prot_hv: assert property (@(posedge clk) disable iff (rst)
    !pins.we_n && op == OP_PROT |->
    pins.addr_bit_nine_hv && pins.oe_hv)
    else $error("protect pulse without high voltage");
  a_unprot_six: assert property (@(posedge clk) disable iff (rst)
    !pins.we_n && op == OP_UNPROT |->
    pins.addr[6] && pins.addr_bit_nine_hv)
    else $error("unlock pulse without addr six high");
  a_verify_addr: assert property (@(posedge clk) disable iff (rst)
    !pins.oe_n && op == OP_VERIFY |-> !pins.addr[0] && !pins.addr[6]
    && pins.addr[1] == addr[1] && pins.addr_bit_nine_hv)
    else $error("verify address wrong");
  // clear pin level must not move under a write pulse
  a_tmp_stable: assert property (@(posedge clk) disable iff (rst)
    !pins.we_n |-> $stable(pins.rst_hv))
    else $error("clear pin level changed during write pulse");
  a_ack_drop: assert property (@(posedge clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_idle_back: assert property (@(posedge clk) disable iff (rst)
    state == S_DONE |=> state == S_IDLE)
    else $error("sequencer stuck in done");

  c_write:   cover property (@(posedge clk) op == OP_WRITE && $rose(pins.we_n));
  c_verify:  cover property (@(posedge clk) op == OP_VERIFY && state == S_DONE);
  c_reject:  cover property (@(posedge clk) $rose(rejected));
  c_unprot:  cover property (@(posedge clk) op == OP_UNPROT && state == S_DONE);
endmodule

// file: verif/fep_flash_model.sv
// behavioural flash on the far side of the host controller
module fep_flash_model
  import fep_pkg::*;
#(
  parameter logic [7:0] ID_CODE = 8'h5C, // arbitrary value
  parameter int         WIN_CYC = 150,
  parameter int         ERS_CYC = 300
) (
  input  wire logic       clk,
  input  wire fep_pins_t  pins,
  input  wire logic [7:0] din,
  output logic      [7:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:63];
  logic [7:0] c, out, last;
  logic [5:0] ci;
  logic [3:0] prot, ers;
  logic [2:0] step;
  logic       prog, idm, tog, wr_q, rd_q, hv_q, cl;
  int         win, run;
  wire [5:0] ix = {pins.addr[17:16], pins.addr[3:0]};
  wire [1:0] sec = pins.addr[17:16];
  wire wr = !pins.ce_n && !pins.we_n && pins.oe_n && !pins.oe_hv;
  wire rd = !pins.ce_n && !pins.oe_n && pins.we_n;
  wire hv = !pins.we_n && !pins.ce_n && pins.addr_bit_nine_hv && pins.oe_hv;
  wire lock = prot[sec] && !pins.rst_hv;
  // power-up lands in read-array mode
  initial begin
    for (int k = 0; k < 64; k++) mem[k] = 8'hFF;
    {prot, ers, step, prog, idm, tog, wr_q, rd_q, hv_q, cl} = '0;
    win = 0; run = 0; last = 8'h00; c = 8'h00; ci = '0;
  end
  // strobes are sampled, so a sub-cycle glitch never opens a write
  always @(posedge clk) begin
    wr_q <= wr; rd_q <= rd; hv_q <= hv; last <= dq;
    if (wr) begin c <= din; ci <= ix; cl <= lock; end
    if (rd_q && !rd && (win > 0 || run > 0)) tog <= !tog;
    if (hv_q && !hv) begin
      if (pins.addr[6]) prot <= 4'h0;
      else prot[sec] <= 1'b1;
    end
    if (win > 0) win <= win - 1;
    if (win == 1) run <= ERS_CYC;
    if (run > 0) run <= run - 1;
    if (run == 1) begin
      for (int k = 0; k < 64; k++) if (ers[k / 16]) mem[k] <= 8'hFF;
      ers <= 4'h0;
    end
    if (wr_q && !wr && run == 0) begin
      step <= 3'd0;
      if (prog) begin
        if (!cl) mem[ci] <= mem[ci] & c;
        prog <= 1'b0;
      end else if (c == 8'hF0) idm <= 1'b0;
      else if ((step == 3'd5 || win > 0) && c == 8'h30) begin
        if (!cl) ers[ci[5:4]] <= 1'b1;
        win <= WIN_CYC;
      end else case ({step, c})
        {3'd0, 8'hAA}: step <= 3'd1;
        {3'd1, 8'h55}: step <= 3'd2;
        {3'd2, 8'hA0}: prog <= 1'b1;
        {3'd2, 8'h80}: step <= 3'd3;
        {3'd2, 8'h90}: idm <= 1'b1;
        {3'd3, 8'hAA}: step <= 3'd4;
        {3'd4, 8'h55}: step <= 3'd5;
        default: ;
      endcase
    end
  end
  // read mux: verify mode, erase status, identity mode, array
  always_comb begin
    if (pins.addr_bit_nine_hv && pins.we_n)
      out = pins.addr[1] ? {7'h00, prot[sec]} : ID_CODE;
    else if (win > 0 || run > 0)
      out = {1'b0, tog, 2'b00, run > 0, 3'b000};
    else if (idm && pins.addr[1]) out = {7'h00, prot[sec]};
    else out = mem[ix];
  end
  // released lines never hold the last byte
  assign dq = rd ? out : ~last;
endmodule

// file: verif/tb.sv
// self-checking bench for the flash erase/protection host controller
module tb import fep_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ID = 8'h5C; // arbitrary value
  logic        clk, rst, cyc, stb, we, dq_oe, ack, tmpu, t;
  logic [7:0]  adr, dq_o, dq, rnd;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, dat_o;
  logic [63:0] q [$];
  fep_pins_t   pins;
  int          errors, checks, seed;
  wire [7:0] dq_i = dq_oe ? dq_o : dq;
  fep_host #(.PROT_CYCLES(4)) u_dut (.clk(clk), .rst(rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .pins(pins), .data_lines_i(dq_i), .data_lines_o(dq_o),
    .data_lines_oe(dq_oe));
  fep_flash_model #(.ID_CODE(ID)) u_flash (.clk(clk), .pins(pins),
    .din(dq_o), .dq(dq));
  task automatic conclude();
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, e, m);
    checks++;
    if ((seen & m) !== (e & m)) begin
      errors++;
      $display("Error read of %h expected %h seen %h", adr, e & m, seen & m);
    end
  endtask
  // one classic cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    // no cycle count assumed; only the watchdog ends a hang
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 0; stb <= 0; we <= 0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
    q.push_back({e, m});
    wb(0, a, 0);
  endtask
  task automatic op(input fep_op_t o, input logic [17:0] a,
                    input logic [7:0] d);
    wb(1, REG_ADDR, {14'h0, a});
    wb(1, REG_WDATA, {24'h0, d});
    wb(1, REG_CTRL, {27'h0, tmpu, o, 1'b1});
    // unused status bits must read zero while polling
    do rd(REG_STATUS, 0, 32'hFFFFFFF0);
    while (rdat[ST_BUSY_BIT] !== 1'b0);
  endtask
  task automatic fw(input logic [17:0] a, input logic [7:0] d);
    op(OP_WRITE, a, d);
  endtask
  task automatic fr(input logic [17:0] a, input logic [7:0] e, m);
    op(OP_READ, a, 0);
    rd(REG_RDATA, {24'h0, e}, {24'h0, m});
  endtask
  task automatic un(); fw(18'h00555, 8'hAA); fw(18'h002AA, 8'h55); endtask
  task automatic pg(input logic [17:0] a, input logic [7:0] d);
    un(); fw(18'h00555, 8'hA0); fw(a, d);
  endtask
  // oldest note against each read answer
  always @(posedge clk)
    if (ack && !we && q.size() > 0) begin
      chk(dat_o, q[0][63:32], q[0][31:0]);
      void'(q.pop_front());
    end
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // hang guard, well past the expected run
  initial begin
    #(25 * 30000);
    errors++;
    conclude();
  end
  initial begin
    seed = 54533; errors = 0; checks = 0; tmpu = 0;
    rst <= 1; cyc <= 0; stb <= 0; we <= 0; adr <= 0; sel <= 0; wdat <= 0;
    repeat (10) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    rd(REG_STATUS, 0, 32'hFFFFFFFF);
    rd(8'h14, 0, 32'hFFFFFFFF);
    fr(18'h00004, 8'hFF, 8'hFF);
    pg(18'h00004, 8'h5A); fr(18'h00004, 8'h5A, 8'hFF);
    un(); fw(18'h00005, 8'h3C); fr(18'h00005, 8'hFF, 8'hFF);
    rnd = 8'($random(seed));
    pg(18'h30003, rnd);
    pg(18'h20000, 8'h11);
    op(OP_PROT, 18'h10000, 0);
    op(OP_VERIFY, 18'h10002, 0); rd(REG_RDATA, 1, 8'hFF);
    op(OP_VERIFY, 18'h00002, 0); rd(REG_RDATA, 0, 8'hFF);
    op(OP_VERIFY, 18'h3FFFD, 0); rd(REG_RDATA, ID, 8'hFF);
    pg(18'h10001, 8'h00); fr(18'h10001, 8'hFF, 8'hFF);
    tmpu = 1; pg(18'h10001, 8'h0F); tmpu = 0;
    pg(18'h10001, 8'h00); fr(18'h10001, 8'h0F, 8'hFF);
    un(); fw(18'h00555, 8'h90); fr(18'h10002, 1, 8'hFF);
    fr(18'h00002, 0, 8'hFF); fw(0, 8'hF0);
    un(); fw(18'h00555, 8'h80); un(); fw(18'h00000, 8'h30);
    fr(0, 0, 8'h88); t = rdat[6];
    op(OP_ADDSEC, 18'h20000, 8'h30);
    fr(0, {1'b0, ~t, 6'h0}, 8'hC8);
    repeat (200) @(posedge clk);
    op(OP_ADDSEC, 18'h30000, 8'h30);
    fr(0, 8'h08, 8'h88);
    rd(REG_STATUS, 32'h6, 32'h6);
    repeat (400) @(posedge clk);
    fr(18'h00004, 8'hFF, 8'hFF); fr(18'h20000, 8'hFF, 8'hFF);
    fr(18'h30003, rnd, 8'hFF);
    // every sector protected before the whole-array unlock
    for (int s = 0; s < 4; s++) op(OP_PROT, {2'(s), 16'h0000}, 0);
    op(OP_VERIFY, 18'h30002, 0); rd(REG_RDATA, 1, 8'hFF);
    op(OP_UNPROT, 18'h00040, 0);
    op(OP_VERIFY, 18'h10002, 0); rd(REG_RDATA, 0, 8'hFF);
    op(OP_VERIFY, 18'h30002, 0); rd(REG_RDATA, 0, 8'hFF);
    conclude();
  end
endmodule
